/* rtc_wakeup_power_control_tb.sv */
// Self-checking bench for the wake-up power-control block
`timescale 1ns/1ps
`include "rwp_map.vh"
module rtc_wakeup_power_control_tb;
    // ****************
    // Stimulus and instances
    // ****************
    reg clk, rst_n, cs_n, oe_n, we_n, osc_clk;
    reg aux_cell, kick_n, ext_on, sup_en;
    reg [4:0] addr;
    reg [7:0] dq_in, sec, rnd, v;
    reg [7:0] al [0:3];
    reg [4:0] aa [0:3];
    reg [1:0] cells;
    wire [7:0] dq_out;
    wire dq_oe_n, sup, pfl, pwr_n, pwr_oe_n, irq_n, irq_oe_n, wave;
    integer err_total, samples_checked, i, k, n_wave;
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Fast oscillator keeps the 256-tick timeout short
    initial
    begin
        osc_clk = 1'b0;
        #5; // Keeps oscillator edges off the clock edges
        forever #130 osc_clk = ~osc_clk;
    end
    rwp_power_ctrl dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .oe_n(oe_n),
        .we_n(we_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .cur_sec(sec), .cur_min(al[1]), .cur_hr(al[2]),
        .cur_day(8'h00), .cur_date(al[3]), .osc_clk(osc_clk),
        .main_supply(sup), .power_fail_level(pfl), .aux_cell(aux_cell),
        .main_cell_low(cells[1]), .aux_cell_low(cells[0]),
        .wdog_timeout(1'b0), .kickstart_in_n(kick_n), .power_on_out_n(pwr_n),
        .power_on_oe_n(pwr_oe_n), .irq_out_n(irq_n), .irq_oe_n(irq_oe_n),
        .square_wave_out(wave));
    rwp_supply_model u_sup (.clk(clk), .rst_n(rst_n), .ext_on(ext_on),
        .sup_en(sup_en), .power_on_oe_n(pwr_oe_n), .main_supply(sup),
        .power_fail_level(pfl));
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Expected control A image
    function [7:0] ea(input power_release_bit, input alarm_match_flag, input kick_event_flag, input irq);
        ea = {cells, 1'b0, power_release_bit, alarm_match_flag, kick_event_flag, 1'b0, irq};
    endfunction
    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Write held low one cycle; the next access leaves a high cycle
    task wr(input [4:0] a, input [7:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        we_n <= 1'b0;
        addr <= a;
        dq_in <= d;
        @(posedge clk);
        cs_n <= 1'b1;
        we_n <= 1'b1;
    endtask
    task rd(input [4:0] a);
        @(posedge clk);
        cs_n <= 1'b0;
        oe_n <= 1'b0;
        addr <= a;
        repeat (2) @(posedge clk);
        v = dq_out;
        cs_n <= 1'b1;
        oe_n <= 1'b1;
    endtask
    // Bounded poll of the interrupt (sel 1) or power-on enable
    task wait_pin(input sel, input lvl, input integer n);
        for (i = 0; i < n && (sel ? irq_oe_n : pwr_oe_n) !== lvl; i = i + 1)
            @(posedge clk);
    endtask
    task kick;
        @(posedge clk);
        kick_n <= 1'b0;
        repeat (40) @(posedge clk);
        kick_n <= 1'b1;
    endtask
    // Count square-wave changes over eight oscillator half periods
    task wave_edges;
        reg last;
        n_wave = 0;
        last = wave;
        repeat (26) @(posedge clk)
        begin
            if (wave !== last)
                n_wave = n_wave + 1;
            last = wave;
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Whole run is near 2000 cycles; ten times that means a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total = err_total + 1;
        stop_test;
    end
    initial
    begin
        {err_total, samples_checked} = 0;
        {rst_n, aux_cell, sup_en, addr, dq_in} = 0;
        {cs_n, oe_n, we_n, kick_n, ext_on} = 5'h1f;
        aa[0] = `RWP_ADDR_ASEC;
        aa[1] = `RWP_ADDR_AMIN;
        aa[2] = `RWP_ADDR_AHR;
        aa[3] = `RWP_ADDR_ADAY;
        rnd = lfsr(8'h12);
        cells = rnd[1:0];
        for (k = 0; k < 4; k = k + 1)
        begin
            rnd = lfsr(rnd);
            al[k] = rnd & 8'h3f;
        end
        sec = al[0] ^ 8'h01;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`RWP_ADDR_MONTH);
        chk("month", v, `RWP_RST_MONTH);
        rd(`RWP_ADDR_CTLB);
        chk("ctlb", v, `RWP_RST_CTLB);
        rd(`RWP_ADDR_CTLA);
        chk("ctla", v, ea(1, 0, 0, 0));
        wave_edges;
        chk("wave on", n_wave > 4, 1);
        rd(5'h1f);
        chk("unmapped", v, 8'h00);
        $display("test reset done");
        for (k = 0; k < 4; k = k + 1)
        begin
            wr(aa[k], al[k]);
            rd(aa[k]);
            chk("alarm", v, al[k]);
        end
        $display("test alarm regs done");
        wr(`RWP_ADDR_CTLB, 8'h08);
        sec <= al[0];
        wait_pin(1, 0, 40);
        sec <= al[0] ^ 8'h01;
        chk("irq", irq_oe_n, 0);
        rd(`RWP_ADDR_CTLA);
        chk("flags", v, ea(1, 1, 0, 1));
        rd(`RWP_ADDR_CTLA);
        chk("read clr", v, ea(1, 0, 0, 0));
        chk("irq off", irq_oe_n, 1);
        sec <= al[0];
        wait_pin(1, 0, 40);
        sec <= al[0] ^ 8'h01;
        wr(`RWP_ADDR_CTLA, 8'h10);
        repeat (3) @(posedge clk);
        chk("irq clr", irq_oe_n, 1);
        $display("test powered alarm done");
        chk("pwr idle", pwr_oe_n, 1);
        wr(`RWP_ADDR_CTLB, 8'h10);
        sec <= al[0];
        wait_pin(0, 0, 40);
        sec <= al[0] ^ 8'h01;
        chk("pwr on", pwr_oe_n, 0);
        rd(`RWP_ADDR_CTLA);
        chk("wake flag", v, ea(0, 1, 0, 0));
        wr(`RWP_ADDR_CTLA, 8'h10);
        repeat (3) @(posedge clk);
        chk("pwr off", pwr_oe_n, 1);
        $display("test wake done");
        wr(`RWP_ADDR_CTLB, 8'h04);
        ext_on <= 1'b0;
        repeat (10) @(posedge clk);
        wave_edges;
        chk("wave off", n_wave == 0, 1);
        kick;
        repeat (60) @(posedge clk);
        chk("no aux", pwr_oe_n, 1);
        aux_cell <= 1'b1;
        wr(`RWP_ADDR_MONTH, 8'h20);
        wave_edges;
        chk("wave aux", n_wave > 4, 1);
        repeat (4) @(posedge clk);
        kick;
        wait_pin(0, 0, 80);
        chk("kick on", pwr_oe_n, 0);
        wait_pin(0, 1, 2500);
        chk("poto", i > 1560 && i < 1720, 1);
        chk("timeout", pwr_oe_n, 1);
        chk("irq float", irq_oe_n, 1);
        $display("test failed power-on done");
        sup_en <= 1'b1;
        kick;
        wait_pin(1, 0, 200);
        chk("irq up", irq_oe_n, 0);
        chk("pwr held", pwr_oe_n, 0);
        rd(`RWP_ADDR_CTLA);
        chk("kick flag", v, ea(0, 0, 1, 1));
        wr(`RWP_ADDR_CTLA, 8'h20);
        sup_en <= 1'b0;
        repeat (10) @(posedge clk);
        chk("fail hold", pwr_oe_n, 0);
        wr(`RWP_ADDR_CTLA, 8'h10);
        repeat (3) @(posedge clk);
        chk("pwr rel", pwr_oe_n, 1);
        $display("test power-on done");
        stop_test;
    end
endmodule // rtc_wakeup_power_control_tb

/* rwp_chk.sv */
// Port-level assertions for the wake-up power-control block
`timescale 1ns/1ps
`include "rwp_map.vh"
module rwp_chk
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Host port
    input wire cs_n,
    input wire oe_n,
    input wire we_n,
    input wire [4:0] addr,
    input wire [7:0] dq_in,
    input wire dq_oe_n,
    // Supply and pins
    input wire osc_clk,
    input wire main_supply,
    input wire power_fail_level,
    input wire aux_cell,
    input wire power_on_out_n,
    input wire power_on_oe_n,
    input wire irq_out_n,
    input wire irq_oe_n,
    input wire square_wave_out
);
    // ****************
    // Properties
    // ****************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire up;
    // Powered only with both comparators high
    assign up = main_supply && power_fail_level;
    sequence s_rel_wr;
        !cs_n && !we_n && addr == `RWP_ADDR_CTLA && dq_in[`RWP_BIT_PWR_REL];
    endsequence
    // Async levels need settling, so look only after four quiet cycles
    sequence s_quiet_up;
        (we_n && up)[*4];
    endsequence
    property p_release;
        s_rel_wr |-> ##[1:3] power_on_oe_n;
    endproperty
    property p_hold;
        s_quiet_up ##0 !power_on_oe_n |=> !power_on_oe_n;
    endproperty
    property p_no_aux;
        (!aux_cell && !up)[*8] |-> !$fell(power_on_oe_n);
    endproperty
    // Supply, aux cell or a register write may also move the wave
    sequence s_wave_quiet;
        $past(up, 3) == $past(up, 4) &&
            $past(aux_cell, 3) == $past(aux_cell, 4) &&
            $past(we_n, 2) && $past(rst_n, 6);
    endsequence
    property p_wave_osc;
        $changed(square_wave_out) ##0 s_wave_quiet |->
            $past(osc_clk, 2) != $past(osc_clk, 5);
    endproperty
    a_release_floats: assert property (p_release)
        else $error("power-on pin still driven after release write");
    a_hold_while_zero: assert property (p_hold)
        else $error("power-on pin dropped without release");
    a_irq_float_down: assert property ((!up)[*5] |-> irq_oe_n)
        else $error("interrupt driven while unpowered");
    a_no_aux_wake: assert property (p_no_aux)
        else $error("power-on raised without aux cell");
    a_pwr_pin_low: assert property (!power_on_oe_n |-> !power_on_out_n)
        else $error("power-on pin driven high");
    a_irq_pin_low: assert property (!irq_oe_n |-> !irq_out_n)
        else $error("interrupt pin driven high");
    a_wave_follows_osc: assert property (p_wave_osc)
        else $error("square wave moved without oscillator edge");
    a_read_drives: assert property ((!cs_n && !oe_n)[*2] |-> !dq_oe_n)
        else $error("data bus not driven during read");
    a_idle_quiet: assert property (cs_n[*2] |-> dq_oe_n)
        else $error("data bus driven while deselected");
endmodule // rwp_chk
bind rwp_power_ctrl rwp_chk u_chk (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
    .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_in(dq_in), .dq_oe_n(dq_oe_n),
    .osc_clk(osc_clk), .main_supply(main_supply), .aux_cell(aux_cell),
    .power_fail_level(power_fail_level), .power_on_out_n(power_on_out_n),
    .power_on_oe_n(power_on_oe_n), .irq_out_n(irq_out_n),
    .irq_oe_n(irq_oe_n), .square_wave_out(square_wave_out));

/* rwp_kick_det.v */
// Kickstart falling-edge detector with minimum low-width filter
`timescale 1ns/1ps
`include "rwp_map.vh"
module rwp_kick_det
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Synchronised kickstart level and oscillator tick
    input wire kick_s,
    input wire tick,
    output reg kick_evt
);
reg [7:0] cnt_q;
reg armed_q;

// Pulse once when input has stayed low for the minimum width
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        cnt_q <= 8'h00;
        armed_q <= 1'b0;
        kick_evt <= 1'b0;
    end
    else
    begin
        kick_evt <= 1'b0;
        if (kick_s)
        begin
            cnt_q <= 8'h00;
            armed_q <= 1'b1;    // High seen: next fall counts
        end
        else if (armed_q && tick)
        begin
            if (cnt_q == `RWP_KICK_TICKS - 8'h01)
            begin
                kick_evt <= 1'b1;
                armed_q <= 1'b0;
            end
            cnt_q <= cnt_q + 8'h01;
        end
    end
end
endmodule // rwp_kick_det

/* rwp_map.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef RWP_MAP_VH
`define RWP_MAP_VH
// Register addresses (5-bit byte bus)
`define RWP_ADDR_ASEC 5'h00
`define RWP_ADDR_AMIN 5'h01
`define RWP_ADDR_AHR 5'h02
`define RWP_ADDR_MONTH 5'h05
`define RWP_ADDR_ADAY 5'h0b
`define RWP_ADDR_CTLA 5'h0e
`define RWP_ADDR_CTLB 5'h0f
// Month register control bits
`define RWP_BIT_OSC_STOP_N 7
`define RWP_BIT_WAVE_EN_N 6
`define RWP_BIT_BB_WAVE 5
// Control A bits
`define RWP_BIT_MAIN_CELL 7
`define RWP_BIT_AUX_CELL 6
`define RWP_BIT_FAIL_HOLD 5
`define RWP_BIT_PWR_REL 4
`define RWP_BIT_ALARM_FLAG 3
`define RWP_BIT_KICK_FLAG 2
`define RWP_BIT_WDOG_FLAG 1
`define RWP_BIT_IRQ_FLAG 0
// Control B bits
`define RWP_BIT_WAKE_EN 4
`define RWP_BIT_ALARM_IE 3
`define RWP_BIT_KICK_IE 2
`define RWP_BIT_WDOG_EN 1
`define RWP_BIT_WDOG_STEER 0
// Reset values
`define RWP_RST_MONTH 8'h00
`define RWP_RST_CTLB 8'h00
`define RWP_RST_PWR_REL 1'b1
// Timing counts in oscillator ticks
`define RWP_POTO_TICKS 16'h0100
`define RWP_KICK_TICKS 8'h04
`endif

/* rwp_power_ctrl.v */
// Wake-up / kickstart power control with byte-wide register port
//
// Overview of operation
// - Wake power enable bit gates alarm wake
// - Unpowered alarm match drives power-on low
// - Wake match also sets alarm flag
// - Filtered kickstart fall powers on, sets flag
// - Detection needs oscillator; aux cell only when unpowered
// - Timeout without supply releases power-on output
// - Failed-attempt flag stays until software clears
// - Successful power-on: interrupt low, release cleared
// - Output active while release bit zero
// - Writing zero flags drops interrupt
// - Powered: events set flags, enabled ones interrupt
// - Powered: enabled events reassert power-on
// - Writing release one floats power-on
// - Interrupt floats below power-fail level
// - Powered down: fail select holds or floats
// - Square wave when enabled, oscillator running
// - Backup square wave on aux cell
// - Cell status bits report low cells
// - Power-up clears listed control bits
// - Flag register read clears alarm flags
`timescale 1ns/1ps
`include "rwp_map.vh"
module rwp_power_ctrl
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Host byte port
    input wire cs_n,
    input wire oe_n,
    input wire we_n,
    input wire [4:0] addr,
    input wire [7:0] dq_in,
    output reg [7:0] dq_out,
    output reg dq_oe_n,
    // Time-of-day from the calendar core
    input wire [7:0] cur_sec,
    input wire [7:0] cur_min,
    input wire [7:0] cur_hr,
    input wire [7:0] cur_day,
    input wire [7:0] cur_date,
    // Oscillator tick (32.768 kHz, asynchronous)
    input wire osc_clk,
    // Analog comparators (asynchronous levels)
    input wire main_supply,
    input wire power_fail_level,
    input wire aux_cell,
    input wire main_cell_low,
    input wire aux_cell_low,
    input wire wdog_timeout,
    // Kickstart pin
    input wire kickstart_in_n,
    // Open-drain outputs, enable low while driving; square wave has no enable
    output reg power_on_out_n,
    output reg power_on_oe_n,
    output reg irq_out_n,
    output reg irq_oe_n,
    output reg square_wave_out
);

// ********************************************************************
// Input synchronisers
// ********************************************************************
// Every level from outside the clock domain goes through one bank,
// so all of them see the same two-cycle latency
wire [7:0] s;
rwp_sync #(.W(8)) u_sync
(
    .clk(clk),
    .rst_n(rst_n),
    .d({osc_clk, main_supply, power_fail_level, aux_cell, main_cell_low,
        aux_cell_low, wdog_timeout, kickstart_in_n}),
    .q(s)
);
wire osc_s = s[7];
wire main_s = s[6];
wire above_pf_s = s[5];
wire aux_s = s[4];
wire main_low_s = s[3];
wire aux_low_s = s[2];
wire wdog_s = s[1];
wire kick_s = s[0];

// ********************************************************************
// Registers
// ********************************************************************
reg [7:0] asec_q, amin_q, ahr_q, aday_q;
reg [7:0] month_q;
reg [7:0] ctlb_q;
reg fail_hold_q, pwr_rel_q;
reg alarm_flag_q, kick_flag_q, wdog_flag_q;
reg osc_d1_q, wdog_d1_q, match_d1_q;
reg pending_q;
reg [15:0] poto_q;
reg pwr_active_q;

wire osc_run = ~month_q[`RWP_BIT_OSC_STOP_N];
wire tick = osc_s & ~osc_d1_q & osc_run;
wire powered = main_s & above_pf_s;

// ********************************************************************
// Alarm match and kickstart detect
// ********************************************************************
wire [5:0] day_cmp = aday_q[6] ? cur_day[5:0] : cur_date[5:0];
wire full_match = (cur_sec[6:0] == asec_q[6:0]) &&
    (cur_min[6:0] == amin_q[6:0]) && (cur_hr[5:0] == ahr_q[5:0]) &&
    (day_cmp == aday_q[5:0]);
wire match_evt = full_match & ~match_d1_q & osc_run;
wire kick_evt;
rwp_kick_det u_kick
(
    .clk(clk),
    .rst_n(rst_n),
    .kick_s(kick_s),
    .tick(tick),
    .kick_evt(kick_evt)
);
wire detect_ok = powered | (aux_s & osc_run);
wire wake_en = ctlb_q[`RWP_BIT_WAKE_EN];
wire kick_en = ctlb_q[`RWP_BIT_KICK_IE];
wire wake_evt = match_evt & wake_en & detect_ok;
wire kwake_evt = kick_evt & kick_en & detect_ok;
wire alarm_set = wake_evt | (match_evt & powered);
wire kick_set = kwake_evt | (kick_evt & powered);

// ********************************************************************
// Host access decode
// ********************************************************************
wire wr = ~cs_n & ~we_n;
reg wr_d1_q, rd_q;
wire wr_stb = wr & ~wr_d1_q;
wire rd_a = ~cs_n & ~oe_n & we_n & (addr == `RWP_ADDR_CTLA);
// Read side effect lands at end of access
wire rd_end = rd_q & ~rd_a;

// ********************************************************************
// Register writes, flags; set wins over any clear
// ********************************************************************
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        asec_q <= 8'h00;
        amin_q <= 8'h00;
        ahr_q <= 8'h00;
        aday_q <= 8'h00;
        month_q <= `RWP_RST_MONTH;
        ctlb_q <= `RWP_RST_CTLB;
        fail_hold_q <= 1'b0;
        pwr_rel_q <= `RWP_RST_PWR_REL;
        alarm_flag_q <= 1'b0;
        kick_flag_q <= 1'b0;
        wdog_flag_q <= 1'b0;
        wr_d1_q <= 1'b0;
        rd_q <= 1'b0;
        osc_d1_q <= 1'b0;
        wdog_d1_q <= 1'b0;
        match_d1_q <= 1'b0;
    end
    else
    begin
        wr_d1_q <= wr;
        rd_q <= rd_a;
        osc_d1_q <= osc_s;
        wdog_d1_q <= wdog_s;
        match_d1_q <= full_match;
        if (wr_stb)
        begin
            case (addr)
                `RWP_ADDR_ASEC: asec_q <= dq_in;
                `RWP_ADDR_AMIN: amin_q <= dq_in;
                `RWP_ADDR_AHR: ahr_q <= dq_in;
                `RWP_ADDR_ADAY: aday_q <= dq_in;
                `RWP_ADDR_MONTH: month_q <= dq_in;
                `RWP_ADDR_CTLB: ctlb_q <= dq_in;
                `RWP_ADDR_CTLA:
                begin
                    fail_hold_q <= dq_in[`RWP_BIT_FAIL_HOLD];
                    pwr_rel_q <= dq_in[`RWP_BIT_PWR_REL];
                    if (!dq_in[`RWP_BIT_ALARM_FLAG])
                        alarm_flag_q <= 1'b0;
                    if (!dq_in[`RWP_BIT_KICK_FLAG])
                        kick_flag_q <= 1'b0;
                end
                default: ;
            endcase
        end
        if (rd_end)
        begin
            alarm_flag_q <= 1'b0;
            wdog_flag_q <= 1'b0;
        end
        // Successful power-up forces the release bit low
        if (pending_q && powered)
            pwr_rel_q <= 1'b0;
        if (wake_evt || kwake_evt)
            pwr_rel_q <= 1'b0;
        // Flags persist through failed attempts until written, or for alarm, read
        if (alarm_set)
            alarm_flag_q <= 1'b1;
        if (kick_set)
            kick_flag_q <= 1'b1;
        if (wdog_s && !wdog_d1_q)
            wdog_flag_q <= 1'b1;
    end
end

// ********************************************************************
// Power-on sequencing and timeout
// ********************************************************************
// A fresh event restarts the timeout, so a bouncing key only
// lengthens the attempt instead of cutting it short
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        pending_q <= 1'b0;
        poto_q <= 16'h0000;
        pwr_active_q <= 1'b0;
    end
    else
    begin
        if (wake_evt || kwake_evt)
        begin
            pwr_active_q <= 1'b1;
            pending_q <= ~powered;
            poto_q <= 16'h0000;
        end
        else if (pending_q)
        begin
            if (powered)
                pending_q <= 1'b0;
            else if (tick)
            begin
                // Supply never arrived: give up the attempt
                if (poto_q == `RWP_POTO_TICKS - 16'h0001)
                begin
                    pending_q <= 1'b0;
                    pwr_active_q <= 1'b0;
                end
                poto_q <= poto_q + 16'h0001;
            end
        end
        else if (powered)
            pwr_active_q <= ~pwr_rel_q;
        else if (!fail_hold_q)
            pwr_active_q <= 1'b0;
    end
end

// ********************************************************************
// Output flops
// ********************************************************************
wire irq_flag = (alarm_flag_q & ctlb_q[`RWP_BIT_ALARM_IE]) |
    (kick_flag_q & ctlb_q[`RWP_BIT_KICK_IE]) |
    (wdog_flag_q & ctlb_q[`RWP_BIT_WDOG_EN] & ~ctlb_q[`RWP_BIT_WDOG_STEER]);
wire wave_on = osc_run & ~month_q[`RWP_BIT_WAVE_EN_N] &
    (powered | (month_q[`RWP_BIT_BB_WAVE] & aux_s));
// Read data is registered so it stands a cycle after the address
reg [7:0] rd_mux;
always @*
begin
    case (addr)
        `RWP_ADDR_ASEC: rd_mux = asec_q;
        `RWP_ADDR_AMIN: rd_mux = amin_q;
        `RWP_ADDR_AHR: rd_mux = ahr_q;
        `RWP_ADDR_ADAY: rd_mux = aday_q;
        `RWP_ADDR_MONTH: rd_mux = month_q;
        `RWP_ADDR_CTLB: rd_mux = ctlb_q;
        `RWP_ADDR_CTLA: rd_mux = {main_low_s, aux_low_s, fail_hold_q,
            pwr_rel_q, alarm_flag_q, kick_flag_q, wdog_flag_q,
            irq_flag};
        default: rd_mux = 8'h00;
    endcase
end

// Square wave toggles on each oscillator edge seen
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        power_on_out_n <= 1'b0;
        power_on_oe_n <= 1'b1;
        irq_out_n <= 1'b0;
        irq_oe_n <= 1'b1;
        square_wave_out <= 1'b0;
        dq_out <= 8'h00;
        dq_oe_n <= 1'b1;
    end
    else
    begin
        power_on_oe_n <= ~pwr_active_q;
        // Interrupt only while supply is above fail level
        irq_oe_n <= ~(irq_flag & powered);
        square_wave_out <= wave_on & osc_s;
        dq_out <= rd_mux;
        dq_oe_n <= ~(~cs_n & ~oe_n & we_n);
    end
end
endmodule // rwp_power_ctrl

/* rwp_supply_model.sv */
// Behavioural main supply switched by the power-on pin
`timescale 1ns/1ps
module rwp_supply_model
#(
    parameter RISE = 20
)
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Bench controls
    input wire ext_on,
    input wire sup_en,
    // Pin and rails
    input wire power_on_oe_n,
    output reg main_supply,
    output wire power_fail_level
);
    // ****************
    // Supply ramp
    // ****************
    integer cnt;
    // A disabled supply stands for one too slow for the timeout
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 0;
            main_supply <= 1'b0;
        end
        else
        begin
            cnt <= power_on_oe_n ? 0 : cnt + 1;
            main_supply <= ext_on || (sup_en && cnt >= RISE);
        end
    end
    // Rail sits above the trip level whenever it is on
    assign power_fail_level = main_supply;
endmodule // rwp_supply_model

/* rwp_sync.v */
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module rwp_sync
#(
    parameter W = 1
)
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
reg [W-1:0] meta_q;

// First stage read only by the second
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        meta_q <= {W{1'b0}};
        q <= {W{1'b0}};
    end
    else
    begin
        meta_q <= d;
        q <= meta_q;
    end
end
endmodule // rwp_sync
